// >>> verilog/epif_top.v
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`include "epif_defines.vh"
module epif_top #(
  parameter HAS_PARALLEL_PORT = 1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire external_irq_1_in,
  input wire external_irq_2_in,
  input wire psp_access_in,
  input wire adc_done_in,
  input wire rx_buffer_full_in,
  input wire tx_buffer_empty_in,
  input wire ssp_done_in,
  input wire [1:0] ccp_mode_in,
  input wire ccp_capture_in,
  input wire ccp_compare_in,
  input wire timer2_match_in,
  input wire timer1_overflow_in,
  input wire [7:0] periph_enable_in,
  input wire [7:0] periph_priority_in,
  output wire irq_high_out,
  output wire irq_low_out,
  output wire irq_out
);
  // external pins pass two flops first
  wire [1:0] ext_sync;
  epif_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({external_irq_2_in, external_irq_1_in}),
    .sync_out(ext_sync)
  );

  // rising edge of each external line is the occurrence
  reg [1:0] ext_prev_q;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_prev_q <= 2'h0;
    end else begin
      ext_prev_q <= ext_sync;
    end
  end
  // prev starts low like an idle pin, so leaving reset makes no false edge
  wire [1:0] ext_event;
  genvar ei;
  generate
    for (ei = 0; ei < 2; ei = ei + 1) begin : g_edge
      assign ext_event[ei] = ext_sync[ei] & ~ext_prev_q[ei];
    end
  endgenerate
  wire ext1_event = ext_event[0];
  wire ext2_event = ext_event[1];

  // bus handshake: one wait cycle, then the access completes
  // the wait state lets read data come straight from a flop
  reg ack_q;
  reg ack_d;
  wire req = avs_read_in | avs_write_in;
  always @* begin
    ack_d = 1'b0;
    if (req & ~ack_q) begin
      ack_d = 1'b1;
    end
  end
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end
  assign avs_waitrequest_out = req & ~ack_q;
  wire done = req & ack_q;
  wire wr_lo = done & avs_write_in & avs_byteenable_in[0];
  wire rd_first = avs_read_in & ~ack_q;

  function sel;
    input [3:0] addr;
    input [3:0] target;
    begin
      sel = (addr == target);
    end
  endfunction

  wire wr_ext = wr_lo & sel(avs_address_in, `EPIF_ADDR_EXT_CTRL);
  wire wr_peri = wr_lo & sel(avs_address_in, `EPIF_ADDR_PERI_FLAGS);
  wire wr_stat = wr_lo & sel(avs_address_in, `EPIF_ADDR_IRQ_STATUS);
  wire wr_mask = wr_lo & sel(avs_address_in, `EPIF_ADDR_IRQ_MASK);
  wire [7:0] wd = avs_writedata_in[7:0];

  // external control register
  reg [7:0] ext_ctrl_q;
  reg [7:0] ext_ctrl_d;
  always @* begin
    ext_ctrl_d = ext_ctrl_q;
    if (wr_ext) begin
      ext_ctrl_d[`EPIF_EXT2_PRIO_BIT] = wd[`EPIF_EXT2_PRIO_BIT];
      ext_ctrl_d[`EPIF_EXT1_PRIO_BIT] = wd[`EPIF_EXT1_PRIO_BIT];
      ext_ctrl_d[`EPIF_EXT2_EN_BIT] = wd[`EPIF_EXT2_EN_BIT];
      ext_ctrl_d[`EPIF_EXT1_EN_BIT] = wd[`EPIF_EXT1_EN_BIT];
      ext_ctrl_d[`EPIF_EXT2_FLAG_BIT] = wd[`EPIF_EXT2_FLAG_BIT];
      ext_ctrl_d[`EPIF_EXT1_FLAG_BIT] = wd[`EPIF_EXT1_FLAG_BIT];
    end
    // unimplemented positions stay zero whatever is written
    ext_ctrl_d = ext_ctrl_d & `EPIF_EXT_CTRL_WMASK;
    // set beats a same-cycle software clear
    if (ext1_event) begin
      ext_ctrl_d[`EPIF_EXT1_FLAG_BIT] = 1'b1;
    end
    if (ext2_event) begin
      ext_ctrl_d[`EPIF_EXT2_FLAG_BIT] = 1'b1;
    end
  end
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_ctrl_q <= `EPIF_EXT_CTRL_RESET;
    end else begin
      ext_ctrl_q <= ext_ctrl_d;
    end
  end

  // peripheral sticky flags; rx and tx are live mirrors
  // pwm and reserved modes never set the flag
  function ccp_hit;
    input [1:0] mode;
    input capture;
    input compare;
    begin
      case (mode)
        `EPIF_CCP_MODE_CAPTURE: begin
          ccp_hit = capture;
        end
        `EPIF_CCP_MODE_COMPARE: begin
          ccp_hit = compare;
        end
        default: begin
          ccp_hit = 1'b0;
        end
      endcase
    end
  endfunction
  wire ccp_event = ccp_hit(ccp_mode_in, ccp_capture_in, ccp_compare_in);

  // rx and tx never set through here, they are mirrors
  function [7:0] peri_events;
    input psp;
    input adc;
    input ssp;
    input ccp;
    input timer2_count;
    input timer1_count;
    begin
      peri_events = 8'h00;
      peri_events[`EPIF_PSP_BIT] = psp & (HAS_PARALLEL_PORT != 0);
      peri_events[`EPIF_ADC_BIT] = adc;
      peri_events[`EPIF_SSP_BIT] = ssp;
      peri_events[`EPIF_CCP_BIT] = ccp;
      peri_events[`EPIF_TIMER2_COUNT_BIT] = timer2_count;
      peri_events[`EPIF_TIMER1_COUNT_BIT] = timer1_count;
    end
  endfunction
  wire [7:0] peri_set = peri_events(psp_access_in, adc_done_in, ssp_done_in, ccp_event,
                                    timer2_match_in, timer1_overflow_in);

  reg [7:0] peri_q;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      if (((`EPIF_PERI_SW_MASK >> gi) & 1) != 0) begin : g_sticky
        always @(posedge clk_in or negedge rst_n_in) begin
          if (!rst_n_in) begin
            peri_q[gi] <= 1'b0;
          end else if (peri_set[gi]) begin
            peri_q[gi] <= 1'b1;
          end else if (wr_peri) begin
            peri_q[gi] <= wd[gi];
          end
        end
      end else begin : g_mirror
        // buffer status lines come from same-clock logic
        always @(posedge clk_in or negedge rst_n_in) begin
          if (!rst_n_in) begin
            peri_q[gi] <= 1'b0;
          end else if (gi == `EPIF_RX_BIT) begin
            peri_q[gi] <= rx_buffer_full_in;
          end else begin
            peri_q[gi] <= tx_buffer_empty_in;
          end
        end
      end
    end
  endgenerate
  reg [7:0] peri_view;
  always @* begin
    peri_view = peri_q;
    if (HAS_PARALLEL_PORT == 0) begin
      peri_view[`EPIF_PSP_BIT] = 1'b0;
    end
  end

  // request routing
  wire ext1_req = ext_ctrl_q[`EPIF_EXT1_FLAG_BIT] & ext_ctrl_q[`EPIF_EXT1_EN_BIT];
  wire ext2_req = ext_ctrl_q[`EPIF_EXT2_FLAG_BIT] & ext_ctrl_q[`EPIF_EXT2_EN_BIT];
  wire [7:0] peri_req = peri_view & periph_enable_in;
  wire [7:0] peri_hi;
  wire [7:0] peri_lo;
  genvar ri;
  generate
    for (ri = 0; ri < 8; ri = ri + 1) begin : g_route
      // each enabled flag goes to exactly one line
      assign peri_hi[ri] = peri_req[ri] & periph_priority_in[ri];
      assign peri_lo[ri] = peri_req[ri] & ~periph_priority_in[ri];
    end
  endgenerate
  wire ext1_hi = ext1_req & ext_ctrl_q[`EPIF_EXT1_PRIO_BIT];
  wire ext1_lo = ext1_req & ~ext_ctrl_q[`EPIF_EXT1_PRIO_BIT];
  wire ext2_hi = ext2_req & ext_ctrl_q[`EPIF_EXT2_PRIO_BIT];
  wire ext2_lo = ext2_req & ~ext_ctrl_q[`EPIF_EXT2_PRIO_BIT];
  wire hi_req = ext1_hi | ext2_hi | (|peri_hi);
  wire lo_req = ext1_lo | ext2_lo | (|peri_lo);
  assign irq_high_out = hi_req;
  assign irq_low_out = lo_req;

  // sticky status of request rises, write one to clear
  reg [1:0] req_prev_q;
  reg [1:0] stat_q;
  reg [1:0] stat_d;
  reg [1:0] mask_q;
  reg [1:0] mask_d;
  wire [1:0] req_now = {lo_req, hi_req};
  wire [1:0] req_rise = req_now & ~req_prev_q;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_prev_q <= 2'h0;
    end else begin
      req_prev_q <= req_now;
    end
  end
  // a rise in the clearing cycle survives the write
  always @* begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wd[1:0];
    end
    stat_d = stat_d | req_rise;
  end
  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = wd[1:0];
    end
  end
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_q <= `EPIF_STAT_RESET;
      mask_q <= `EPIF_MASK_RESET;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end
  assign irq_out = |(stat_q & mask_q);

  // read mux, unmapped reads return zero
  reg [31:0] rd_mux_d;
  always @* begin
    rd_mux_d = 32'h00000000;
    case (avs_address_in)
      `EPIF_ADDR_EXT_CTRL: begin
        rd_mux_d = {24'h000000, ext_ctrl_q};
      end
      `EPIF_ADDR_PERI_FLAGS: begin
        rd_mux_d = {24'h000000, peri_view};
      end
      `EPIF_ADDR_IRQ_STATUS: begin
        rd_mux_d = {30'h0, stat_q};
      end
      `EPIF_ADDR_IRQ_MASK: begin
        rd_mux_d = {30'h0, mask_q};
      end
      default: begin
        rd_mux_d = 32'h00000000;
      end
    endcase
  end
  // captured on the first request cycle, held through the wait state
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (rd_first) begin
      avs_readdata_out <= rd_mux_d;
    end
  end
endmodule

// >>> inc/epif_defines.vh
`ifndef EPIF_DEFINES_VH
`define EPIF_DEFINES_VH
// register word byte addresses
`define EPIF_ADDR_EXT_CTRL 4'h0
`define EPIF_ADDR_PERI_FLAGS 4'h4
`define EPIF_ADDR_IRQ_STATUS 4'h8
`define EPIF_ADDR_IRQ_MASK 4'hC
// ext_int_control fields
`define EPIF_EXT2_PRIO_BIT 7
`define EPIF_EXT1_PRIO_BIT 6
`define EPIF_EXT2_EN_BIT 4
`define EPIF_EXT1_EN_BIT 3
`define EPIF_EXT2_FLAG_BIT 1
`define EPIF_EXT1_FLAG_BIT 0
`define EPIF_EXT_CTRL_RESET 8'hC0
`define EPIF_EXT_CTRL_WMASK 8'hDB
// peripheral_flags_low fields
`define EPIF_PSP_BIT 7
`define EPIF_ADC_BIT 6
`define EPIF_RX_BIT 5
`define EPIF_TX_BIT 4
`define EPIF_SSP_BIT 3
`define EPIF_CCP_BIT 2
`define EPIF_TIMER2_COUNT_BIT 1
`define EPIF_TIMER1_COUNT_BIT 0
`define EPIF_PERI_RESET 8'h00
`define EPIF_PERI_SW_MASK 8'hCF
// software-visible status: bit0 high request, bit1 low request
`define EPIF_STAT_RESET 2'h0
`define EPIF_MASK_RESET 2'h0
// capture/compare modes
`define EPIF_CCP_MODE_CAPTURE 2'h0
`define EPIF_CCP_MODE_COMPARE 2'h1
`define EPIF_CCP_MODE_PWM 2'h2
`endif

// >>> verilog/epif_sync2.v
`timescale 1ns/100ps
`include "epif_defines.vh"
module epif_sync2 #(
  parameter WIDTH = 2
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule

// >>> dv/epif_top_properties.sv
`timescale 1ns/100ps
module epif_top_properties (
  input wire clk_in,
  input wire rst_n_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire adc_done_in,
  input wire rx_buffer_full_in,
  input wire tx_buffer_empty_in,
  input wire [7:0] periph_enable_in,
  input wire [7:0] periph_priority_in,
  input wire irq_high_out,
  input wire irq_low_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire rd_done = avs_read_in && !avs_waitrequest_out;
  wire [31:0] rdv = avs_readdata_out;
  sequence s_ack;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  property p_rd_wait;
    $rose(avs_read_in) |-> s_ack;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_wait;
    $rose(avs_write_in) |-> s_ack;
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait state wrong");
  property p_route_hi;
    adc_done_in && periph_enable_in[6] && periph_priority_in[6] |=> irq_high_out;
  endproperty
  a_route_hi: assert property (p_route_hi) else $error("high request missing");
  property p_route_lo;
    adc_done_in && periph_enable_in[6] && !periph_priority_in[6] |=> irq_low_out;
  endproperty
  a_route_lo: assert property (p_route_lo) else $error("low request missing");
  property p_width;
    rd_done |-> rdv[31:8] == 24'h000000 && (avs_address_in[1:0] == 2'h0 || rdv == 32'h0);
  endproperty
  a_width: assert property (p_width) else $error("stray read data bits");
  property p_ctrl_rsv;
    rd_done && avs_address_in == 4'h0 |-> rdv[5] == 1'b0 && rdv[2] == 1'b0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bit read one");
  property p_rx;
    rd_done && avs_address_in == 4'h4 && $stable(rx_buffer_full_in) && $past(rx_buffer_full_in, 2)
      == rx_buffer_full_in |-> rdv[5] == rx_buffer_full_in;
  endproperty
  a_rx: assert property (p_rx) else $error("rx flag not mirrored");
  property p_tx;
    rd_done && avs_address_in == 4'h4 && $stable(tx_buffer_empty_in) && $past(tx_buffer_empty_in, 2)
      == tx_buffer_empty_in |-> rdv[4] == tx_buffer_empty_in;
  endproperty
  a_tx: assert property (p_tx) else $error("tx flag not mirrored");
endmodule

// >>> dv/epif_periph_model.sv
`timescale 1ns/100ps
module epif_periph_model (
  input wire clk_in,
  input wire [7:0] fire_in,
  output reg [7:0] pulse_out
);
  // sources emit single-cycle strobes on the core clock
  always @(posedge clk_in) begin
    pulse_out <= fire_in;
  end
endmodule

// >>> dv/epif_top_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin \
  miscompares = miscompares + 1; $display("BAD %0t got %h exp %h", $time, a, b); end end
module epif_top_tb_top;
  reg clk_in = 0;
  reg rst_n_in = 0;
  reg [3:0] addr = 4'h0;
  reg rd = 0;
  reg wr = 0;
  reg [31:0] wdata = 32'h0;
  reg x1 = 0;
  reg x2 = 0;
  reg rx = 0;
  reg tx = 0;
  reg [1:0] mode = 2'h0;
  reg [7:0] fire = 8'h00;
  reg [7:0] en = 8'h00;
  reg [7:0] pri = 8'h00;
  reg [31:0] got;
  wire [31:0] rdata;
  wire [7:0] ev;
  wire waitreq, ihi, ilo, irq;
  integer miscompares = 0;
  integer tests_run = 0;
  integer i;
  epif_periph_model epif_periph_model_inst (.clk_in(clk_in), .fire_in(fire), .pulse_out(ev));
  epif_top epif_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .external_irq_1_in(x1),
    .external_irq_2_in(x2), .psp_access_in(ev[7]), .adc_done_in(ev[6]), .rx_buffer_full_in(rx),
    .tx_buffer_empty_in(tx), .ssp_done_in(ev[3]), .ccp_mode_in(mode), .ccp_capture_in(ev[2]),
    .ccp_compare_in(ev[5]), .timer2_match_in(ev[1]), .timer1_overflow_in(ev[0]),
    .periph_enable_in(en), .periph_priority_in(pri), .irq_high_out(ihi), .irq_low_out(ilo),
    .irq_out(irq));
  initial forever #2.5 clk_in = ~clk_in;
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task bus(input w, input [3:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge clk_in);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      n = 0;
      @(posedge clk_in);
      while (waitreq !== 1'b0 && n < 50) begin
        @(posedge clk_in);
        n = n + 1;
      end
      if (n == 50) miscompares = miscompares + 1;
      got = rdata;
      rd <= 0;
      wr <= 0;
    end
  endtask
  task rd8(input [3:0] a, input [31:0] e);
    begin
      bus(0, a, 8'h00);
      `CHK(got, e)
    end
  endtask
  task t_reset;
    begin
      rd8(4'h0, 32'hC0);
      rd8(4'h4, 32'h00);
      rd8(4'h1, 32'h00);
      bus(1, 4'h0, 8'hFF);
      rd8(4'h0, 32'hDB);
      bus(1, 4'h0, 8'h00);
      rd8(4'h0, 32'h00);
      $display("reset and control test done");
    end
  endtask
  task t_ext;
    begin
      x1 <= 1;
      repeat (6) @(posedge clk_in);
      rd8(4'h0, 32'h01);
      x2 <= 1;
      repeat (6) @(posedge clk_in);
      rd8(4'h0, 32'h03);
      `CHK({ihi, ilo}, 2'b00)
      bus(1, 4'h0, 8'h4B);
      @(posedge clk_in);
      `CHK({ihi, ilo}, 2'b10)
      bus(1, 4'h0, 8'h12);
      @(posedge clk_in);
      `CHK({ihi, ilo}, 2'b01)
      bus(1, 4'h0, 8'h10);
      @(posedge clk_in);
      `CHK({ihi, ilo}, 2'b00)
      $display("external test done");
    end
  endtask
  task t_periph;
    // byte i: source strobe, expected flags; two-bit field i: capture/compare mode
    reg [63:0] fires, exps;
    reg [15:0] modes;
    begin
      fires = 64'h8040080201042004;
      exps = 64'h8040080201040400;
      modes = 16'h0006;
      rx <= 1;
      tx <= 1;
      for (i = 0; i < 8; i = i + 1) begin
        mode <= modes[2*i +: 2];
        fire <= fires[8*i +: 8];
        @(posedge clk_in);
        fire <= 8'h00;
        repeat (3) @(posedge clk_in);
        rd8(4'h4, {24'h0, exps[8*i +: 8] | 8'h30});
        bus(1, 4'h4, 8'h00);
        rd8(4'h4, 32'h30);
      end
      rx <= 0;
      tx <= 0;
      repeat (3) @(posedge clk_in);
      rd8(4'h4, 32'h00);
      $display("peripheral flag test done");
    end
  endtask
  task t_irq;
    begin
      bus(1, 4'h8, 8'h03);
      rd8(4'h8, 32'h00);
      en <= 8'h40;
      pri <= 8'h40;
      fire <= 8'h40;
      @(posedge clk_in);
      fire <= 8'h00;
      repeat (2) @(posedge clk_in);
      `CHK({ihi, ilo}, 2'b10)
      rd8(4'h8, 32'h01);
      bus(1, 4'hC, 8'h01);
      @(posedge clk_in);
      `CHK(irq, 1'b1)
      bus(1, 4'h4, 8'h00);
      bus(1, 4'h8, 8'h01);
      @(posedge clk_in);
      `CHK(irq, 1'b0)
      pri <= 8'h00;
      fire <= 8'h40;
      @(posedge clk_in);
      fire <= 8'h00;
      repeat (2) @(posedge clk_in);
      `CHK({ihi, ilo}, 2'b01)
      $display("interrupt test done");
    end
  endtask
  initial begin
    #200000;
    miscompares = miscompares + 1;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1;
    t_reset;
    t_ext;
    t_periph;
    t_irq;
    stop_test;
  end
endmodule
bind epif_top epif_top_properties epif_top_properties_inst (.*);
